// ==== core/mps_pkg.sv ====
// package for the margin and phase-shed configuration block
// assumes a serial slave elsewhere delivers completed register writes
package mps_pkg;
    localparam logic [7:0] MPS_ADDR_NB = 8'h00;
    localparam logic [7:0] MPS_ADDR_CORE = 8'h01;
    localparam logic [7:0] MPS_ADDR_PS = 8'h02;
    localparam logic [7:0] MPS_RST_NB = 8'h00;
    localparam logic [7:0] MPS_RST_CORE = 8'h00;
    localparam logic [7:0] MPS_RST_PS = 8'h01;
    localparam logic [7:0] MPS_PS_WR_MASK = 8'h7f;
    localparam int MPS_OVP_BIT = 7;
    localparam int MPS_PG_BIT = 6;
    localparam int MPS_PS_OFFDIS_BIT = 6;
    // voltages in mV, then phase counts
    localparam int MPS_OVP_FLOOR_MV = 1800;
    localparam int MPS_OVP_LO_MV = 250;
    localparam int MPS_OVP_HI_MV = 500;
    localparam int MPS_PG_CORE_UP_LO_MV = 250;
    localparam int MPS_PG_CORE_UP_HI_MV = 300;
    localparam int MPS_PG_DN_LO_MV = 300;
    localparam int MPS_PG_DN_HI_MV = 350;
    localparam int MPS_PG_HYST_MV = 50;
    localparam int MPS_OFFSET_STEP_MV = 25;
    localparam int MPS_MAX_PHASES = 4;
    localparam logic [2:0] MPS_ALL_PHASES = 3'd4;

    typedef struct packed {
        logic [15:0] ovp_trip_mv;
        logic [15:0] pg_upper_mv;
        logic [15:0] pg_lower_mv;
        logic signed [15:0] offset_mv;
    } mps_rail_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } mps_write_type;

    typedef enum logic [1:0] {
        MPS_FULL = 2'b00,
        MPS_SHED = 2'b01,
        MPS_SAVE = 2'b11,
        MPS_ADD = 2'b10
    } mps_state_type;
endpackage : mps_pkg

// ==== core/mps_rail_decode.sv ====
// one regulator's decode of an 8-bit margin register plus power-good hysteresis
// assumes voltages in mV as unsigned 16-bit values
`timescale 1ns/1ns
module mps_rail_decode
    import mps_pkg::*;
#(
    parameter bit IS_CORE = 1'b0
) (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic [7:0] cfg, // margin register
    input wire logic offset_gate, // drop offset
    input wire logic [15:0] nominal_target_voltage, // dac mV
    input wire logic [15:0] sensed_mv, // sensed output mV
    output mps_rail_type rail, // decoded thresholds
    output logic power_good // hysteretic status
);
    logic signed [15:0] offs;
    logic [15:0] ovp_sum;
    logic [15:0] up_mv;
    logic [15:0] dn_mv;
    logic pg_reg;
    logic pg_next;

    always_comb begin
        offs = offset_gate ? 16'sh0000
            : 16'(signed'(cfg[5:0]) * 16'(MPS_OFFSET_STEP_MV));
        ovp_sum = nominal_target_voltage
            + (cfg[MPS_OVP_BIT] ? 16'(MPS_OVP_HI_MV) : 16'(MPS_OVP_LO_MV));
        up_mv = nominal_target_voltage
            + (cfg[MPS_PG_BIT] ? 16'(MPS_PG_CORE_UP_HI_MV) : 16'(MPS_PG_CORE_UP_LO_MV));
        if (!IS_CORE) begin
            up_mv = 16'hffff;
        end
        dn_mv = nominal_target_voltage
            - (cfg[MPS_PG_BIT] ? 16'(MPS_PG_DN_HI_MV) : 16'(MPS_PG_DN_LO_MV));
        rail.ovp_trip_mv = (ovp_sum > 16'(MPS_OVP_FLOOR_MV)) ? ovp_sum : 16'(MPS_OVP_FLOOR_MV);
        rail.pg_upper_mv = up_mv;
        rail.pg_lower_mv = dn_mv;
        rail.offset_mv = offs;
        if (pg_reg) begin
            pg_next = (sensed_mv >= dn_mv) && (sensed_mv <= up_mv);
        end else begin
            pg_next = (sensed_mv >= dn_mv + 16'(MPS_PG_HYST_MV))
                && (IS_CORE ? sensed_mv + 16'(MPS_PG_HYST_MV) <= up_mv : 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pg_reg <= 1'b0;
        end else begin
            pg_reg <= pg_next;
        end
    end
    assign power_good = pg_reg;

    a_pg_hyst_hold: assert property (@(posedge clk) disable iff (srst)
        pg_reg && sensed_mv >= dn_mv && sensed_mv <= up_mv |=> pg_reg)
        else $error("power good dropped inside window");
endmodule : mps_rail_decode

// ==== core/mps_margin_shed.sv ====
// top of the margin and phase-shed configuration block
// assumes the serial slave hands completed writes and a pwm cycle pulse
`timescale 1ns/1ns
module mps_margin_shed
    import mps_pkg::*;
(
    input wire logic clk, // 125 MHz clock
    input wire logic srst, // sync reset, power-on
    input wire logic wr_done, // write transaction complete
    input mps_write_type wr, // completed write
    input wire logic [7:0] rd_addr, // current read address
    output logic [7:0] rd_data, // read data
    input wire logic pwm_cycle, // one pulse per pwm cycle
    input wire logic power_saving_request, // high requests saving
    input wire logic [15:0] nb_target_mv, // nb dac mV
    input wire logic [15:0] core_target_mv, // core dac mV
    input wire logic [15:0] nb_sense_mv, // nb sensed mV
    input wire logic [15:0] core_sense_mv, // core sensed mV
    output mps_rail_type nb_rail, // nb thresholds
    output mps_rail_type core_rail, // core thresholds
    output logic nb_power_good, // nb status
    output logic core_power_good, // core status
    output logic [2:0] active_phases, // phases running
    output logic saving_mode // in saving mode
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] nb_cfg_reg;
    logic [7:0] nb_cfg_next;
    logic [7:0] core_cfg_reg;
    logic [7:0] core_cfg_next;
    logic [7:0] ps_cfg_reg;
    logic [7:0] ps_cfg_next;

    always_comb begin
        nb_cfg_next = nb_cfg_reg;
        core_cfg_next = core_cfg_reg;
        ps_cfg_next = ps_cfg_reg;
        if (wr_done) begin
            case (wr.addr)
                MPS_ADDR_NB: nb_cfg_next = wr.data;
                MPS_ADDR_CORE: core_cfg_next = wr.data;
                MPS_ADDR_PS: ps_cfg_next = wr.data & MPS_PS_WR_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            nb_cfg_reg <= MPS_RST_NB;
            core_cfg_reg <= MPS_RST_CORE;
            ps_cfg_reg <= MPS_RST_PS;
        end else begin
            nb_cfg_reg <= nb_cfg_next;
            core_cfg_reg <= core_cfg_next;
            ps_cfg_reg <= ps_cfg_next;
        end
    end

    logic [7:0] rd_next;
    logic [7:0] rd_reg;
    always_comb begin
        case (rd_addr)
            MPS_ADDR_NB: rd_next = nb_cfg_reg;
            MPS_ADDR_CORE: rd_next = core_cfg_reg;
            MPS_ADDR_PS: rd_next = ps_cfg_reg;
            default: rd_next = 8'h00;
        endcase
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_reg <= 8'h00;
        end else begin
            rd_reg <= rd_next;
        end
    end
    assign rd_data = rd_reg;

    // ------------------------------------------------------------
    // phase shedding
    // ------------------------------------------------------------
    mps_state_type st_reg;
    mps_state_type st_next;
    logic [2:0] ph_reg;
    logic [2:0] ph_next;
    logic [2:0] wait_reg;
    logic [2:0] wait_next;
    logic [2:0] target_ph;
    logic [2:0] drop_gap;
    logic [2:0] add_gap;

    // spacing code to cycles; code 3 gives zero cycles, meaning all at once
    function automatic logic [2:0] gap_cycles(input logic [1:0] code);
        case (code)
            2'b00: gap_cycles = 3'd1;
            2'b01: gap_cycles = 3'd2;
            2'b10: gap_cycles = 3'd4;
            default: gap_cycles = 3'd0;
        endcase
    endfunction : gap_cycles

    always_comb begin
        target_ph = ps_cfg_reg[1] ? 3'd3 : (ps_cfg_reg[0] ? 3'd2 : 3'd1);
        drop_gap = gap_cycles(ps_cfg_reg[5:4]);
        add_gap = gap_cycles(ps_cfg_reg[3:2]);
        st_next = st_reg;
        ph_next = ph_reg;
        wait_next = wait_reg;
        case (st_reg)
            MPS_FULL: begin
                if (power_saving_request) begin
                    st_next = MPS_SHED;
                    wait_next = drop_gap;
                end
            end
            MPS_SHED: begin
                if (!power_saving_request) begin
                    st_next = MPS_ADD;
                    wait_next = add_gap;
                end else if (ph_reg <= target_ph) begin
                    st_next = MPS_SAVE;
                    // target raised mid-shed: take it at once, as saving does
                    ph_next = target_ph;
                end else if (drop_gap == 3'd0) begin
                    ph_next = target_ph;
                end else if (pwm_cycle) begin
                    if (wait_reg <= 3'd1) begin
                        ph_next = ph_reg - 3'd1;
                        wait_next = drop_gap;
                    end else begin
                        wait_next = wait_reg - 3'd1;
                    end
                end
            end
            MPS_SAVE: begin
                if (!power_saving_request) begin
                    st_next = MPS_ADD;
                    wait_next = add_gap;
                end else if (ph_reg != target_ph) begin
                    st_next = MPS_SHED;
                    wait_next = drop_gap;
                    if (ph_reg < target_ph) begin
                        ph_next = target_ph;
                    end
                end
            end
            MPS_ADD: begin
                if (power_saving_request) begin
                    st_next = MPS_SHED;
                    wait_next = drop_gap;
                end else if (ph_reg >= MPS_ALL_PHASES) begin
                    st_next = MPS_FULL;
                end else if (add_gap == 3'd0) begin
                    ph_next = MPS_ALL_PHASES;
                end else if (pwm_cycle) begin
                    if (wait_reg <= 3'd1) begin
                        ph_next = ph_reg + 3'd1;
                        wait_next = add_gap;
                    end else begin
                        wait_next = wait_reg - 3'd1;
                    end
                end
            end
            default: begin
                st_next = MPS_FULL;
                ph_next = MPS_ALL_PHASES;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= MPS_FULL;
            ph_reg <= MPS_ALL_PHASES;
            wait_reg <= 3'd0;
        end else begin
            st_reg <= st_next;
            ph_reg <= ph_next;
            wait_reg <= wait_next;
        end
    end

    assign active_phases = ph_reg;
    assign saving_mode = (st_reg == MPS_SHED) || (st_reg == MPS_SAVE);

    // ------------------------------------------------------------
    // rail decode
    // ------------------------------------------------------------
    logic core_off_gate;
    assign core_off_gate = saving_mode && ps_cfg_reg[MPS_PS_OFFDIS_BIT];

    mps_rail_decode #(.IS_CORE(1'b0)) u_nb (
        .clk(clk),
        .srst(srst),
        .cfg(nb_cfg_reg),
        .offset_gate(1'b0),
        .nominal_target_voltage(nb_target_mv),
        .sensed_mv(nb_sense_mv),
        .rail(nb_rail),
        .power_good(nb_power_good)
    );
    mps_rail_decode #(.IS_CORE(1'b1)) u_core (
        .clk(clk),
        .srst(srst),
        .cfg(core_cfg_reg),
        .offset_gate(core_off_gate),
        .nominal_target_voltage(core_target_mv),
        .sensed_mv(core_sense_mv),
        .rail(core_rail),
        .power_good(core_power_good)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_values: assert property (@(posedge clk)
        srst |=> nb_cfg_reg == MPS_RST_NB && ps_cfg_reg == MPS_RST_PS)
        else $error("reset values wrong");
    a_write_applies: assert property (@(posedge clk) disable iff (srst)
        wr_done && wr.addr == MPS_ADDR_CORE |=> core_cfg_reg == $past(wr.data))
        else $error("core write not applied");
    a_addr_decode: assert property (@(posedge clk) disable iff (srst)
        wr_done && wr.addr == MPS_ADDR_NB |=> $stable(core_cfg_reg) && $stable(ps_cfg_reg))
        else $error("write hit wrong register");
    a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
        ps_cfg_reg[7] == 1'b0)
        else $error("reserved bit stored");
    a_ovp_floor: assert property (@(posedge clk) disable iff (srst)
        core_rail.ovp_trip_mv >= 16'(MPS_OVP_FLOOR_MV))
        else $error("overvoltage trip below floor");
    a_offset_gate: assert property (@(posedge clk) disable iff (srst)
        saving_mode && ps_cfg_reg[MPS_PS_OFFDIS_BIT] |-> core_rail.offset_mv == 16'sh0000)
        else $error("core offset applied while disabled");
    a_nb_offset: assert property (@(posedge clk) disable iff (srst)
        nb_cfg_reg[5:0] == 6'h20 |-> nb_rail.offset_mv == -16'sd800)
        else $error("offset decode wrong");
    a_save_count: assert property (@(posedge clk) disable iff (srst)
        st_reg == MPS_SAVE && $stable(ps_cfg_reg) |-> ph_reg == target_ph)
        else $error("saving phase count wrong");
    a_drop_at_once: assert property (@(posedge clk) disable iff (srst)
        st_reg == MPS_SHED && power_saving_request && drop_gap == 3'd0
        && ph_reg > target_ph |=> ph_reg == target_ph)
        else $error("drop at once failed");
    a_add_at_once: assert property (@(posedge clk) disable iff (srst)
        st_reg == MPS_ADD && !power_saving_request && add_gap == 3'd0 |=> ph_reg == MPS_ALL_PHASES)
        else $error("add at once failed");
    a_enter_saving: assert property (@(posedge clk) disable iff (srst)
        st_reg == MPS_FULL && power_saving_request |=> saving_mode)
        else $error("saving not entered");
    a_leave_saving: assert property (@(posedge clk) disable iff (srst)
        saving_mode && !power_saving_request |=> !saving_mode)
        else $error("saving not left");
    a_read_decode: assert property (@(posedge clk) disable iff (srst)
        rd_addr == MPS_ADDR_PS |=> rd_data == $past(ps_cfg_reg))
        else $error("read data wrong");
    a_unmapped_ignored: assert property (@(posedge clk) disable iff (srst)
        wr_done && wr.addr > MPS_ADDR_PS
        |=> $stable(nb_cfg_reg) && $stable(core_cfg_reg) && $stable(ps_cfg_reg))
        else $error("unmapped write stored");
    a_phase_range: assert property (@(posedge clk) disable iff (srst)
        active_phases >= 3'd1 && active_phases <= MPS_ALL_PHASES)
        else $error("phase count out of range");
    a_drop_single: assert property (@(posedge clk) disable iff (srst)
        st_reg == MPS_SHED && drop_gap != 3'd0 && ph_reg > target_ph
        |=> ph_reg + 3'd1 >= $past(ph_reg))
        else $error("more than one phase dropped");
    a_add_single: assert property (@(posedge clk) disable iff (srst)
        st_reg == MPS_ADD && add_gap != 3'd0 |=> ph_reg <= $past(ph_reg) + 3'd1)
        else $error("more than one phase added");

    c_shed: cover property (@(posedge clk) disable iff (srst) st_reg == MPS_SAVE);
    c_readd: cover property (@(posedge clk) disable iff (srst)
        st_reg == MPS_ADD ##1 st_reg == MPS_FULL);
    c_pg: cover property (@(posedge clk) disable iff (srst) core_power_good);
    c_step_add: cover property (@(posedge clk) disable iff (srst)
        st_reg == MPS_ADD && pwm_cycle && wait_reg <= 3'd1 && add_gap != 3'd0);
    c_offset_gated: cover property (@(posedge clk) disable iff (srst) core_off_gate);
endmodule : mps_margin_shed

// ==== verification/mps_host_model.sv ====
// far side model: completed-write source and free running pwm cycle pulses
// assumes the block samples writes on the rising clk edge
`timescale 1ns/1ns
module mps_host_model
    import mps_pkg::*;
(
    input wire logic clk, // clock
    output logic wr_done, // write complete pulse
    output mps_write_type wr, // write contents
    output logic pwm_cycle, // pwm cycle pulse
    output logic power_saving_request // saving request
);
    logic [2:0] pwm_cnt = 3'h0;

    initial begin
        wr_done = 1'b0;
        wr = '0;
        power_saving_request = 1'b0;
    end

    // pwm never pauses, so five clocks give the spacing unit
    always @(posedge clk) begin
        pwm_cnt <= (pwm_cnt == 3'h4) ? 3'h0 : pwm_cnt + 3'h1;
    end
    assign pwm_cycle = (pwm_cnt == 3'h4);

    // released bus shows inverted contents, not a stale copy
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_done <= 1'b1;
        wr <= '{addr: a, data: d};
        @(posedge clk);
        wr_done <= 1'b0;
        wr <= '{addr: ~a, data: ~d};
    endtask : write_reg
endmodule : mps_host_model

// ==== verification/margin_and_phase_shed_config_tb.sv ====
// testbench: decode rows, read back, hysteresis, phase shedding, reset
// assumes the host model pulses pwm_cycle every five clocks
`timescale 1ns/1ns
module margin_and_phase_shed_config_tb import mps_pkg::*;;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [15:0] t;
        logic [63:0] e;
    } mps_row_type;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr_done, pwm_cycle, req, nb_pg, core_pg, saving_mode;
    mps_write_type wr;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data;
    logic [15:0] nb_t = 16'h03e8;
    logic [15:0] core_t = 16'h03e8;
    logic [15:0] nb_s = 16'h0578;
    logic [15:0] core_s = 16'h0578;
    mps_rail_type nb_rail, core_rail;
    logic [2:0] active_phases;
    int err_total = 0;
    int n_tests = 0;
    mps_row_type rows [6] = '{
        '{8'h00, 8'h00, 16'h03e8, {16'h0708, 16'hffff, 16'h02bc, 16'h0000}},
        '{8'h00, 8'h20, 16'h03e8, {16'h0708, 16'hffff, 16'h02bc, 16'hfce0}},
        '{8'h00, 8'hc1, 16'h05dc, {16'h07d0, 16'hffff, 16'h047e, 16'h0019}},
        '{8'h01, 8'h20, 16'h0640, {16'h073a, 16'h073a, 16'h0514, 16'hfce0}},
        '{8'h01, 8'h5f, 16'h04b0, {16'h0708, 16'h05dc, 16'h0352, 16'h0307}},
        '{8'h01, 8'hbf, 16'h0578, {16'h076c, 16'h0672, 16'h044c, 16'hffe7}}};

    always #4 clk = ~clk;

    mps_host_model i_mps_host_model (.clk(clk), .wr_done(wr_done), .wr(wr),
        .pwm_cycle(pwm_cycle), .power_saving_request(req));
    mps_margin_shed i_mps_margin_shed (.clk(clk), .srst(srst), .wr_done(wr_done), .wr(wr),
        .rd_addr(rd_addr), .rd_data(rd_data), .pwm_cycle(pwm_cycle),
        .power_saving_request(req), .nb_target_mv(nb_t), .core_target_mv(core_t),
        .nb_sense_mv(nb_s), .core_sense_mv(core_s), .nb_rail(nb_rail),
        .core_rail(core_rail), .nb_power_good(nb_pg), .core_power_good(core_pg),
        .active_phases(active_phases), .saving_mode(saving_mode));

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        chk("rd_data", rd_data, exp);
    endtask : rd_chk

    task automatic pg_step(input logic [15:0] s, input logic exp);
        @(posedge clk);
        core_s <= s;
        repeat (3) @(posedge clk);
        #1;
        chk("core_pg", core_pg, exp);
    endtask : pg_step

    // pulses between steps measured at the ports
    task automatic shed_run(input logic [7:0] ps, input logic r, input logic [2:0] fin,
        input int sp);
        logic [2:0] last;
        int cnt;
        int guard;
        logic p;
        i_mps_host_model.write_reg(MPS_ADDR_PS, ps);
        #1;
        last = active_phases;
        cnt = 0;
        guard = 0;
        @(posedge clk);
        i_mps_host_model.power_saving_request <= r;
        // the edge that takes the request counts no pulse
        @(posedge clk);
        #1;
        while (active_phases !== fin && guard < 200) begin
            p = pwm_cycle;
            @(posedge clk);
            #1;
            cnt += int'(p);
            if (active_phases !== last) begin
                chk("phase_step", active_phases,
                    (sp == 0) ? fin : (r ? last - 3'h1 : last + 3'h1));
                if (sp != 0) chk("phase_gap", 64'(cnt), 64'(sp));
                last = active_phases;
                cnt = 0;
            end
            guard++;
        end
        repeat (2) @(posedge clk);
        #1;
        chk("phase_final", active_phases, fin);
        chk("saving_mode", saving_mode, r);
    endtask : shed_run

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("phases_rst", active_phases, MPS_ALL_PHASES);
        chk("nb_pg_rst", nb_pg, 1'b0);
        rd_chk(MPS_ADDR_NB, MPS_RST_NB);
        rd_chk(MPS_ADDR_CORE, MPS_RST_CORE);
        rd_chk(MPS_ADDR_PS, MPS_RST_PS);
        rd_chk(8'h03, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk);
            nb_t <= rows[i].t;
            core_t <= rows[i].t;
            i_mps_host_model.write_reg(rows[i].a, rows[i].d);
            #1;
            if (rows[i].a == MPS_ADDR_NB) chk("nb_rail", nb_rail, rows[i].e);
            else chk("core_rail", core_rail, rows[i].e);
            rd_chk(rows[i].a, rows[i].d);
        end
        rd_chk(MPS_ADDR_NB, 8'hc1);
        i_mps_host_model.write_reg(8'h03, 8'h55);
        rd_chk(MPS_ADDR_NB, 8'hc1);
        i_mps_host_model.write_reg(MPS_ADDR_PS, 8'hff);
        rd_chk(MPS_ADDR_PS, 8'h7f);
        // window 1100 to 1650, return needs 50 inside
        pg_step(16'h0578, 1'b1);
        pg_step(16'h0438, 1'b0);
        pg_step(16'h0460, 1'b0);
        pg_step(16'h0488, 1'b1);
        pg_step(16'h065e, 1'b1);
        pg_step(16'h0686, 1'b0);
        pg_step(16'h0654, 1'b0);
        pg_step(16'h0636, 1'b1);
        chk("nb_pg", nb_pg, 1'b1);
        shed_run(8'h18, 1'b1, 3'h1, 2);
        shed_run(8'h18, 1'b0, 3'h4, 4);
        i_mps_host_model.write_reg(MPS_ADDR_CORE, 8'h05);
        shed_run(8'h7e, 1'b1, 3'h3, 0);
        chk("core_off_save", core_rail.offset_mv, 16'h0000);
        chk("nb_off_save", nb_rail.offset_mv, 16'h0019);
        shed_run(8'h7e, 1'b0, 3'h4, 0);
        chk("core_off_full", core_rail.offset_mv, 16'h007d);
        shed_run(8'h05, 1'b1, 3'h2, 1);
        chk("core_off_keep", core_rail.offset_mv, 16'h007d);
        shed_run(8'h05, 1'b0, 3'h4, 2);
        shed_run(8'h23, 1'b1, 3'h3, 4);
        shed_run(8'h23, 1'b0, 3'h4, 1);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd_chk(MPS_ADDR_NB, MPS_RST_NB);
        rd_chk(MPS_ADDR_PS, MPS_RST_PS);
        rd_chk(MPS_ADDR_CORE, MPS_RST_CORE);
        tally_and_finish();
    end
endmodule : margin_and_phase_shed_config_tb
